// ==== usb_dual_serial_bridge.sv ====
// USB bridge to a main-processor byte channel and an 8N1 TTL serial port
// Functional notes
// - Communication channel moves bytes both ways well above twenty kilobytes per second.
// - Host bytes on the communication channel are held for the main processor to fetch.
// - Main processor bytes on the communication channel are forwarded to the host.
// - RTS and DTR states are set only by the host, readable by main processor.
// - Mirrored DTR follows host changes promptly, meaning terminal connected or not.
// - Communication channel ignores the host baud setting entirely.
// - Serial port runs at the host-selected baud rate, 300 to 115200 bps.
// - Every host byte for the serial port is shifted out on the transmit line.
// - Every byte framed on the receive line is forwarded to the host while queue 3 has room; one framed while it is full is dropped.
// - Frames are eight data bits, no parity, one stop bit; line idles high.
// - Serial port runs independently of the main processor.
// - Host sees programmer, communication channel, then serial port, in that order.
`default_nettype none

module usb_dual_serial_bridge (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Host writes to the communication channel
  input  wire logic        commInValid,
  input  wire logic [7:0]  commInData,
  output logic             commInReady,
  // Host writes to the serial port channel
  input  wire logic        ttlInValid,
  input  wire logic [7:0]  ttlInData,
  output logic             ttlInReady,
  // Bytes returned to the host, tagged by interface number
  input  wire logic        hostOutReady,
  output logic             hostOutValid,
  output logic [1:0]       hostOutChan,
  output logic [7:0]       hostOutData,
  // Host line settings
  input  wire logic        hostCtrlWr,
  input  wire logic        hostRts,
  input  wire logic        hostDtr,
  input  wire logic        hostBaudWr,
  input  wire logic [17:0] hostBaudDiv,
  // Main processor side
  input  wire logic        mainRxReady,
  output logic             mainRxValid,
  output logic [7:0]       mainRxData,
  input  wire logic        mainTxValid,
  input  wire logic [7:0]  mainTxData,
  output logic             mainTxReady,
  output logic             mainRts,
  output logic             mainDtr,
  // Serial pins
  input  wire logic        serialRx,
  output logic             serialTx
);

  typedef struct packed {
    logic [17:0]             div;
    logic                    rts;
    logic                    dtr;
    logic                    outValid;
    logic [1:0]              outChan;
    logic [7:0]              outData;
    bridge_pkg::line_state_t txSt;
    logic [17:0]             txCnt;
    logic [2:0]              txBit;
    logic [7:0]              txSh;
    logic                    txLine;
    bridge_pkg::line_state_t rxSt;
    logic [17:0]             rxCnt;
    logic [2:0]              rxBit;
    logic [7:0]              rxSh;
    logic                    rxPush;
    logic [7:0]              rxByte;
  } bridge_state_t;

  bridge_state_t q;
  bridge_state_t d;
  logic          loadOut;
  logic          takeComm;
  logic          takeTtl;

  // ==========================================================================
  // Queues: 0 host to main, 1 main to host, 2 host to line, 3 line to host
  // ==========================================================================
  fifo_if fq [bridge_pkg::NUM_FIFOS] ();

  generate
    for (genvar i = 0; i < bridge_pkg::NUM_FIFOS; i++)
    begin : g_fifo
      byte_fifo u_fifo (
        .clk  (clk),
        .rst  (rst),
        .port (fq[i])
      );
    end
  endgenerate

  // Single-cycle queue handshakes carry far more than the needed rate
  assign fq[0].pushValid = commInValid;
  assign fq[0].pushData  = commInData;
  assign fq[0].popReady  = mainRxReady;
  assign fq[1].pushValid = mainTxValid;
  assign fq[1].pushData  = mainTxData;
  assign fq[1].popReady  = takeComm;
  assign fq[2].pushValid = ttlInValid;
  assign fq[2].pushData  = ttlInData;
  assign fq[2].popReady  = (q.txSt == bridge_pkg::LINE_IDLE);
  assign fq[3].pushValid = q.rxPush;
  assign fq[3].pushData  = q.rxByte;
  assign fq[3].popReady  = takeTtl;

  // Communication channel wins; serial bytes wait while it streams
  assign loadOut  = !q.outValid || hostOutReady;
  assign takeComm = loadOut && fq[1].popValid;
  assign takeTtl  = loadOut && !fq[1].popValid && fq[3].popValid;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    d        = q;
    d.rxPush = 1'b0;

    // Handshake mirrors written only by the host
    if (hostCtrlWr)
    begin
      d.rts = hostRts;
      d.dtr = hostDtr;
    end

    // Baud only steers the serial port, clamped to the legal span
    if (hostBaudWr)
    begin
      if (hostBaudDiv < bridge_pkg::DIV_MIN)
        d.div = bridge_pkg::DIV_MIN;
      else if (hostBaudDiv > bridge_pkg::DIV_MAX)
        d.div = bridge_pkg::DIV_MAX;
      else
        d.div = hostBaudDiv;
    end

    // Return path to the host, tagged with the interface number
    if (loadOut)
    begin
      d.outValid = takeComm || takeTtl;
      d.outChan  = takeComm ? bridge_pkg::CHAN_COMM : bridge_pkg::CHAN_TTL;
      d.outData  = takeComm ? fq[1].popData : fq[3].popData;
    end

    // Transmitter, 8N1, LSB first
    case (q.txSt)
      bridge_pkg::LINE_IDLE:
      begin
        d.txLine = 1'b1;
        if (fq[2].popValid)
        begin
          d.txSh   = fq[2].popData;
          d.txLine = 1'b0;
          d.txCnt  = q.div - 18'h1;
          d.txSt   = bridge_pkg::LINE_START;
        end
      end
      bridge_pkg::LINE_START:
      begin
        if (q.txCnt == 18'h0)
        begin
          d.txLine = q.txSh[0];
          d.txBit  = 3'h0;
          d.txCnt  = q.div - 18'h1;
          d.txSt   = bridge_pkg::LINE_DATA;
        end
        else
          d.txCnt = q.txCnt - 18'h1;
      end
      bridge_pkg::LINE_DATA:
      begin
        if (q.txCnt == 18'h0)
        begin
          d.txCnt = q.div - 18'h1;
          if (q.txBit == 3'h7)
          begin
            d.txLine = 1'b1;
            d.txSt   = bridge_pkg::LINE_STOP;
          end
          else
          begin
            d.txSh   = {1'b0, q.txSh[7:1]};
            d.txLine = q.txSh[1];
            d.txBit  = q.txBit + 3'h1;
          end
        end
        else
          d.txCnt = q.txCnt - 18'h1;
      end
      bridge_pkg::LINE_STOP:
      begin
        if (q.txCnt == 18'h0)
          d.txSt = bridge_pkg::LINE_IDLE;
        else
          d.txCnt = q.txCnt - 18'h1;
      end
      default:
      begin
        d.txSt   = bridge_pkg::LINE_IDLE;
        d.txLine = 1'b1;
      end
    endcase

    // Receiver samples mid-bit; a glitch shorter than half a bit is rejected
    case (q.rxSt)
      bridge_pkg::LINE_IDLE:
      begin
        if (!serialRx)
        begin
          d.rxCnt = {1'b0, q.div[17:1]};
          d.rxSt  = bridge_pkg::LINE_START;
        end
      end
      bridge_pkg::LINE_START:
      begin
        if (q.rxCnt != 18'h0)
          d.rxCnt = q.rxCnt - 18'h1;
        else if (!serialRx)
        begin
          d.rxCnt = q.div - 18'h1;
          d.rxBit = 3'h0;
          d.rxSt  = bridge_pkg::LINE_DATA;
        end
        else
          d.rxSt = bridge_pkg::LINE_IDLE;
      end
      bridge_pkg::LINE_DATA:
      begin
        if (q.rxCnt == 18'h0)
        begin
          d.rxSh  = {serialRx, q.rxSh[7:1]};
          d.rxCnt = q.div - 18'h1;
          d.rxBit = q.rxBit + 3'h1;
          if (q.rxBit == 3'h7)
            d.rxSt = bridge_pkg::LINE_STOP;
        end
        else
          d.rxCnt = q.rxCnt - 18'h1;
      end
      bridge_pkg::LINE_STOP:
      begin
        if (q.rxCnt == 18'h0)
        begin
          // Framing error drops the byte
          d.rxPush = serialRx;
          d.rxByte = q.rxSh;
          d.rxSt   = bridge_pkg::LINE_IDLE;
        end
        else
          d.rxCnt = q.rxCnt - 18'h1;
      end
      default:
        d.rxSt = bridge_pkg::LINE_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q        <= '0;
      q.div    <= bridge_pkg::DIV_RESET;
      q.txLine <= 1'b1;
    end
    else
      q <= d;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign commInReady  = fq[0].pushReady;
  assign ttlInReady   = fq[2].pushReady;
  assign mainTxReady  = fq[1].pushReady;
  assign mainRxValid  = fq[0].popValid;
  assign mainRxData   = fq[0].popData;
  assign hostOutValid = q.outValid;
  assign hostOutChan  = q.outChan;
  assign hostOutData  = q.outData;
  assign mainRts      = q.rts;
  assign mainDtr      = q.dtr;
  assign serialTx     = q.txLine;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_dtr_follows_host: assert property (hostCtrlWr |=> mainDtr == $past(hostDtr))
    else $error("DTR mirror did not follow host");
  a_rts_follows_host: assert property (!hostCtrlWr |=> mainRts == $past(mainRts))
    else $error("RTS mirror changed without host write");
  a_tx_idle_high: assert property (q.txSt == bridge_pkg::LINE_IDLE |-> serialTx)
    else $error("transmit line low while idle");
  a_tx_start_bit: assert property (
    q.txSt == bridge_pkg::LINE_IDLE && fq[2].popValid
      |=> !serialTx && q.txSt == bridge_pkg::LINE_START && q.txSh == $past(fq[2].popData))
    else $error("queued byte did not start a frame");
  a_tx_stop_high: assert property (q.txSt == bridge_pkg::LINE_STOP |-> serialTx)
    else $error("stop bit not high");
  a_rx_bad_drop: assert property (
    q.rxSt == bridge_pkg::LINE_STOP && q.rxCnt == 18'h0 && !serialRx |=> !q.rxPush)
    else $error("byte with low stop bit forwarded");
  a_rx_good_push: assert property (
    q.rxSt == bridge_pkg::LINE_STOP && q.rxCnt == 18'h0 && serialRx
      |=> q.rxPush && q.rxByte == $past(q.rxSh))
    else $error("good frame not forwarded");
  a_baud_in_range: assert property (
    q.div >= bridge_pkg::DIV_MIN && q.div <= bridge_pkg::DIV_MAX)
    else $error("bit time outside legal rates");
  a_comm_first: assert property (
    loadOut && fq[1].popValid |=> hostOutValid && hostOutChan == bridge_pkg::CHAN_COMM)
    else $error("communication byte not sent on its interface");

  c_tx_frame:  cover property (q.txSt == bridge_pkg::LINE_STOP ##1 q.txSt == bridge_pkg::LINE_IDLE);
  c_rx_push:   cover property (q.rxPush);
  c_rx_drop:   cover property (q.rxSt == bridge_pkg::LINE_STOP && q.rxCnt == 18'h0 && !serialRx);
  c_ttl_out:   cover property (hostOutValid && hostOutReady && hostOutChan == bridge_pkg::CHAN_TTL);

endmodule : usb_dual_serial_bridge

`default_nettype wire

// ==== bridge_pkg.sv ====
// Shared constants and types for the USB dual serial bridge
`default_nettype none

package bridge_pkg;

  // ==========================================================================
  // Clock and serial rates
  // ==========================================================================
  localparam int          CLK_HZ    = 50_000_000;
  localparam int          BAUD_MIN  = 300;
  localparam int          BAUD_MAX  = 115200;
  localparam int          DIV_W     = 18;
  // Bit time in clock cycles: fastest rate rounds down, slowest rounds down
  localparam logic [17:0] DIV_MIN   = 18'(CLK_HZ / BAUD_MAX);
  localparam logic [17:0] DIV_MAX   = 18'(CLK_HZ / BAUD_MIN);
  localparam logic [17:0] DIV_RESET = DIV_MIN;

  // ==========================================================================
  // Queues
  // ==========================================================================
  localparam int          FIFO_DEPTH = 16;
  localparam int          PTR_W      = 4;
  localparam int          CNT_W      = 5;
  localparam int          NUM_FIFOS  = 4;

  // ==========================================================================
  // Host-visible serial interfaces, in enumeration order
  // ==========================================================================
  localparam logic [1:0]  CHAN_PROG = 2'h0;
  localparam logic [1:0]  CHAN_COMM = 2'h1;
  localparam logic [1:0]  CHAN_TTL  = 2'h2;

  typedef enum logic [1:0] {
    LINE_IDLE  = 2'b00,
    LINE_START = 2'b01,
    LINE_DATA  = 2'b10,
    LINE_STOP  = 2'b11
  } line_state_t;

endpackage : bridge_pkg

`default_nettype wire

// ==== fifo_if.sv ====
// Byte queue connection between the bridge and its queues
`default_nettype none

interface fifo_if;
  logic       pushValid;
  logic [7:0] pushData;
  logic       pushReady;
  logic       popValid;
  logic [7:0] popData;
  logic       popReady;

  modport store (input pushValid, input pushData, input popReady,
                 output pushReady, output popValid, output popData);
  modport user  (output pushValid, output pushData, output popReady,
                 input pushReady, input popValid, input popData);
endinterface : fifo_if

`default_nettype wire

// ==== byte_fifo.sv ====
// First-in first-out byte queue with registered full and non-empty flags
`default_nettype none

module byte_fifo (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Queue ports
  fifo_if.store    port
);

  typedef struct packed {
    logic [bridge_pkg::FIFO_DEPTH-1:0][7:0] mem;
    logic [bridge_pkg::PTR_W-1:0]           wr;
    logic [bridge_pkg::PTR_W-1:0]           rd;
    logic [bridge_pkg::CNT_W-1:0]           cnt;
    logic                                   full;
    logic                                   hasData;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t d;
  logic        push;
  logic        pop;

  // ==========================================================================
  // Queue update
  // ==========================================================================
  assign push = port.pushValid && !q.full;
  assign pop  = port.popReady && q.hasData;

  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wr] = port.pushData;
      d.wr        = q.wr + 4'h1;
    end
    if (pop)
      d.rd = q.rd + 4'h1;
    d.cnt     = q.cnt + 5'(push) - 5'(pop);
    d.full    = (d.cnt == 5'(bridge_pkg::FIFO_DEPTH));
    d.hasData = (d.cnt != 5'h00);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign port.pushReady = !q.full;
  assign port.popValid  = q.hasData;
  assign port.popData   = q.mem[q.rd];

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_fifo_bound: assert property (q.cnt <= 5'(bridge_pkg::FIFO_DEPTH))
    else $error("queue count above depth");
  a_fifo_drain: assert property (pop && !push |=> q.cnt == $past(q.cnt) - 5'h01)
    else $error("queue count not reduced by a pop");
  a_fifo_head: assert property (
    push && !q.hasData |=> port.popData == $past(port.pushData))
    else $error("first byte into empty queue not at head");

endmodule : byte_fifo

`default_nettype wire

// ==== serial_peer.sv ====
// External 8N1 serial device facing the bridge's TTL pins
`default_nettype none

module serial_peer (
  // Clock used to count bit times
  input  wire logic clk,
  // Serial pins, seen from the far side
  input  wire logic serialTx,
  output var  logic serialRx
);
  timeunit 1ns;
  timeprecision 1ps;

  int         bitTime  = 434;
  int         frameErr = 0;
  logic [7:0] got[$];

  initial serialRx = 1'b1;

  // ==========================================================================
  // Sender: start low, LSB first, stop bit chosen by caller
  // ==========================================================================
  task automatic sendByte(input logic [7:0] d, input logic stopBit);
    logic [9:0] f;
    f = {stopBit, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      serialRx = f[i];
      repeat (bitTime) @(negedge clk);
    end
    // Idle high gap so a bad stop cannot merge into the next frame
    serialRx = 1'b1;
    repeat (bitTime) @(negedge clk);
  endtask : sendByte

  // ==========================================================================
  // Receiver: samples mid-bit on falling clock edges, away from updates
  // ==========================================================================
  always
  begin
    logic [7:0] b;
    @(negedge serialTx);
    repeat (bitTime / 2) @(negedge clk);
    if (serialTx !== 1'b0) frameErr++;
    for (int i = 0; i < 8; i++)
    begin
      repeat (bitTime) @(negedge clk);
      b[i] = serialTx;
    end
    repeat (bitTime) @(negedge clk);
    if (serialTx !== 1'b1) frameErr++;
    got.push_back(b);
  end
endmodule : serial_peer

`default_nettype wire

// ==== usb_dual_serial_bridge_tb_top.sv ====
// Self-checking bench for the USB dual serial bridge
`default_nettype none

module usb_dual_serial_bridge_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0, rst = 1'b1;
  logic        commInValid = 1'b0, ttlInValid = 1'b0, mainTxValid = 1'b0;
  logic        hostCtrlWr = 1'b0, hostBaudWr = 1'b0, hostRts = 1'b0, hostDtr = 1'b0;
  logic        mainRxReady = 1'b0, hostOutReady = 1'b0;
  logic [7:0]  commInData = 8'h00, ttlInData = 8'h00, mainTxData = 8'h00;
  logic [17:0] hostBaudDiv = 18'h001b2;
  logic        commInReady, ttlInReady, hostOutValid, mainRxValid, mainTxReady;
  logic        mainRts, mainDtr, serialRx, serialTx;
  logic [1:0]  hostOutChan;
  logic [7:0]  hostOutData, mainRxData, d;
  logic [9:0]  hostQ[$], expQ[$];
  int          fails = 0, tests_run = 0;

  always #10 clk = ~clk;

  usb_dual_serial_bridge DUT (
    .clk(clk), .rst(rst),
    .commInValid(commInValid), .commInData(commInData), .commInReady(commInReady),
    .ttlInValid(ttlInValid), .ttlInData(ttlInData), .ttlInReady(ttlInReady),
    .hostOutReady(hostOutReady), .hostOutValid(hostOutValid),
    .hostOutChan(hostOutChan), .hostOutData(hostOutData),
    .hostCtrlWr(hostCtrlWr), .hostRts(hostRts), .hostDtr(hostDtr),
    .hostBaudWr(hostBaudWr), .hostBaudDiv(hostBaudDiv),
    .mainRxReady(mainRxReady), .mainRxValid(mainRxValid), .mainRxData(mainRxData),
    .mainTxValid(mainTxValid), .mainTxData(mainTxData), .mainTxReady(mainTxReady),
    .mainRts(mainRts), .mainDtr(mainDtr), .serialRx(serialRx), .serialTx(serialTx)
  );

  serial_peer peer (.clk(clk), .serialTx(serialTx), .serialRx(serialRx));

  // ==========================================================================
  // Host side: random stalls on the return path, capture what is taken
  // ==========================================================================
  always @(negedge clk) hostOutReady <= ($urandom_range(3) != 0);

  always @(posedge clk)
    if (!rst && hostOutValid === 1'b1 && hostOutReady)
      hostQ.push_back({hostOutChan, hostOutData});

  // ==========================================================================
  // Checking and closing
  // ==========================================================================
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic hang;
    fails++;
    close_out;
  endtask : hang

  // Push into comm (0), serial (1) or main (2) queue once it has room
  task automatic push(input int which, input logic [7:0] v);
    int n;
    n = 0;
    @(negedge clk);
    while ((which == 0 ? commInReady : which == 1 ? ttlInReady : mainTxReady) !== 1'b1)
    begin
      n++;
      if (n > 1000) hang;
      @(negedge clk);
    end
    case (which)
      0: {commInValid, commInData} = {1'b1, v};
      1: {ttlInValid, ttlInData} = {1'b1, v};
      default: {mainTxValid, mainTxData} = {1'b1, v};
    endcase
    @(negedge clk);
    {commInValid, ttlInValid, mainTxValid} = 3'b000;
  endtask : push

  task automatic popMain(input logic [7:0] e);
    int n;
    n = 0;
    @(negedge clk);
    while (mainRxValid !== 1'b1)
    begin
      n++;
      if (n > 1000) hang;
      @(negedge clk);
    end
    chk({8'h00, mainRxData}, {8'h00, e});
    mainRxReady = 1'b1;
    @(negedge clk);
    mainRxReady = 1'b0;
  endtask : popMain

  // Bound covers three frames at the slowest divisor used here
  task automatic waitCount(input int which, input int cnt);
    int n;
    n = 0;
    while ((which == 0 ? hostQ.size() : peer.got.size()) < cnt)
    begin
      n++;
      if (n > 20000) hang;
      @(negedge clk);
    end
  endtask : waitCount

  // Serial traffic both ways; byte 1 received with a low stop bit
  task automatic serialRound(input int n);
    logic [7:0] txQ[$];
    int         good;
    good = 0;
    for (int i = 0; i < n; i++)
    begin
      d = 8'($urandom);
      txQ.push_back(d);
      push(1, d);
    end
    waitCount(1, n);
    for (int i = 0; i < n; i++)
      chk({8'h00, peer.got.pop_front()}, {8'h00, txQ.pop_front()});
    chk(16'(peer.frameErr), 16'h0000);
    for (int i = 0; i < n; i++)
    begin
      d = 8'($urandom);
      if (i != 1)
      begin
        expQ.push_back({bridge_pkg::CHAN_TTL, d});
        good++;
      end
      peer.sendByte(d, i != 1);
    end
    waitCount(0, good);
    repeat (600) @(negedge clk);
    chk(16'(hostQ.size()), 16'(good));
    while (expQ.size() > 0)
      chk({6'h00, hostQ.pop_front()}, {6'h00, expQ.pop_front()});
  endtask : serialRound

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    void'($urandom(32'h3eec));
    repeat (4) @(negedge clk);
    rst = 1'b0;
    chk({8'h00, commInReady, ttlInReady, mainTxReady, mainRxValid, hostOutValid,
         mainRts, mainDtr, serialTx}, 16'h00e1);
    $display("test reset done");

    // Handshake mirrors; inputs flipped with no strobe must not leak
    for (int i = 0; i < 4; i++)
    begin
      @(negedge clk);
      {hostCtrlWr, hostRts, hostDtr} = {1'b1, 2'(i)};
      @(negedge clk);
      {hostCtrlWr, hostRts, hostDtr} = {1'b0, ~2'(i)};
      chk({14'h0000, mainRts, mainDtr}, 16'(i));
      @(negedge clk);
      chk({14'h0000, mainRts, mainDtr}, 16'(i));
    end
    $display("test handshake done");

    // Comm channel filled to refusal, then drained in order
    for (int i = 0; i < 16; i++)
    begin
      d = 8'($urandom);
      expQ.push_back({2'h0, d});
      push(0, d);
    end
    @(negedge clk);
    chk({15'h0000, commInReady}, 16'h0000);
    for (int i = 0; i < 16; i++)
      popMain(8'(expQ.pop_front()));
    $display("test comm to main done");

    // Main processor to host, one push every other cycle
    for (int i = 0; i < 6; i++)
    begin
      d = 8'($urandom);
      expQ.push_back({bridge_pkg::CHAN_COMM, d});
      push(2, d);
    end
    waitCount(0, 6);
    for (int i = 0; i < 6; i++)
      chk({6'h00, hostQ.pop_front()}, {6'h00, expQ.pop_front()});
    $display("test main to host done");

    serialRound(3);
    $display("test serial default rate done");

    // New bit time; comm channel must not care
    // Too short a bit time first: the clamp must keep the divisor legal
    @(negedge clk);
    {hostBaudWr, hostBaudDiv} = {1'b1, 18'h00001};
    @(negedge clk);
    {hostBaudWr, hostBaudDiv} = {1'b1, 18'h001f4};
    @(negedge clk);
    hostBaudWr = 1'b0;
    peer.bitTime = 500;
    d = 8'($urandom);
    push(0, d);
    popMain(d);
    serialRound(2);
    $display("test serial new rate done");
    close_out;
  end

  initial
  begin
    repeat (100000) @(posedge clk);
    hang;
  end
endmodule : usb_dual_serial_bridge_tb_top

`default_nettype wire
